// >>> usc_line_partner.sv
// Remote serial transceiver on the far side of the line
`timescale 1ns/100ps
module usc_line_partner (
    input  wire logic pclk,
    input  wire logic line_from_dut,
    output logic      line_to_dut
);
    // Line idles high between frames; each bit lasts four clocks
    initial line_to_dut = 1'b1;
    task automatic send(input logic [8:0] b, input logic nine = 1'b0, input logic stop = 1'b1);
        logic [11:0] f;
        int          nb;
        f  = nine ? {1'b1, stop, b, 1'b0} : {2'b11, stop, b[7:0], 1'b0};
        nb = nine ? 11 : 10;
        for (int i = 0; i < nb; i++) begin
            @(posedge pclk);
            line_to_dut <= f[i];
            repeat (3) @(posedge pclk);
        end
        // A broken stop bit leaves the line low; let it go high again
        if (!stop) begin
            @(posedge pclk);
            line_to_dut <= 1'b1;
            repeat (3) @(posedge pclk);
        end
    endtask
    // Samples mid-bit after the start edge
    task automatic recv(output logic [7:0] b);
        int n;
        n = 0;
        while (line_from_dut !== 1'b0 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (4) @(posedge pclk);
            b[i] = line_from_dut;
        end
    endtask
endmodule // usc_line_partner

// >>> usc_pkg.sv
// Constants and types shared by the serial port status and control block
package usc_pkg;
    // Register indices; the byte address on the bus is four times the index
    localparam logic [9:0]  USC_IDX_MODE   = 10'h220;
    localparam logic [9:0]  USC_IDX_STAT   = 10'h222;
    localparam logic [9:0]  USC_IDX_TXD    = 10'h224;
    localparam logic [9:0]  USC_IDX_RXD    = 10'h226;
    localparam logic [9:0]  USC_IDX_BRG    = 10'h228;
    localparam logic [15:0] USC_MODE_RST   = 16'h0000;
    localparam logic [15:0] USC_STAT_RST   = 16'h0110;
    localparam logic [15:0] USC_BRG_RST    = 16'h0000;
    localparam logic [15:0] USC_MODE_WMASK = 16'hb4ff;
    // Mode register fields
    localparam int USC_M_ON    = 15;
    localparam int USC_M_INFRARED_CODEC_ENABLE  = 12;
    localparam int USC_M_BRGH  = 3;
    localparam int USC_M_PDS   = 1;
    localparam int USC_M_STSEL = 0;
    // Status and control register fields
    localparam int USC_S_TXI1  = 15;
    localparam int USC_S_INV   = 14;
    localparam int USC_S_TXI0  = 13;
    localparam int USC_S_BRK   = 11;
    localparam int USC_S_TXEN  = 10;
    localparam int USC_S_RXI   = 6;
    localparam int USC_S_ADDRESS_DETECT_ENABLE = 5;
    localparam int USC_S_OVERRUN_FLAG  = 1;
    // Buffer and bit timing
    localparam int          USC_DEPTH      = 4;
    localparam logic [2:0]  USC_CNT_FULL   = 3'd4;
    localparam logic [2:0]  USC_CNT_3Q     = 3'd3;
    localparam logic [3:0]  USC_LAST_STD   = 4'hf;
    localparam logic [3:0]  USC_LAST_HI    = 4'h3;
    localparam logic [3:0]  USC_HALF_STD   = 4'h7;
    localparam logic [3:0]  USC_HALF_HI    = 4'h1;
    localparam logic [3:0]  USC_IR_PULSE   = 4'h3;
    localparam logic [3:0]  USC_BREAK_BITS = 4'hc;
    localparam logic [3:0]  USC_BITS8      = 4'h8;
    localparam logic [3:0]  USC_BITS9      = 4'h9;
    // Encodings
    localparam logic [1:0]  USC_TXI_EACH   = 2'h0;
    localparam logic [1:0]  USC_TXI_DONE   = 2'h1;
    localparam logic [1:0]  USC_TXI_EMPTY  = 2'h2;
    localparam logic [1:0]  USC_RXI_3Q     = 2'h2;
    localparam logic [1:0]  USC_RXI_FULL   = 2'h3;
    localparam logic [1:0]  USC_PDS_EVEN   = 2'h1;
    localparam logic [1:0]  USC_PDS_ODD    = 2'h2;
    localparam logic [1:0]  USC_PDS_NINE   = 2'h3;
    typedef enum logic [2:0] {USC_IDLE, USC_START, USC_DATA, USC_PAR, USC_STOP} usc_st_t;
endpackage

// >>> usc_uart_status_control.sv
// Serial port status and control logic with APB register access
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
module usc_uart_status_control
    import usc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_in,
    output logic             serial_out_pin,
    output logic             serial_out_pin_oe_n,
    output logic             tx_irq,
    output logic             rx_irq
);
    // ==========================================================
    // Register bus
    logic        pready_r, pslverr_r;
    logic [31:0] prdata_r;
    logic [15:0] mode_r, brg_r;
    logic [1:0]  tx_sel_r, rx_sel_r;
    logic        inv_r, brk_r, txen_r, address_detect_enable_r, overrun_flag_r;
    logic        tx_irq_r, rx_irq_r, pin_r, oe_n_r;

    // Answer one cycle into the access phase; the write lands one edge later, when ready is sampled
    wire       acc      = psel & penable & ~pready_r;
    wire       xfer     = psel & penable & pready_r;
    wire       wr       = xfer & pwrite;
    wire       rd       = xfer & ~pwrite;
    wire [9:0] idx      = paddr[11:2];
    wire       algn     = paddr[1:0] == 2'h0;
    wire       hit_mode = algn & (idx == USC_IDX_MODE);
    wire       hit_stat = algn & (idx == USC_IDX_STAT);
    wire       hit_txd  = algn & (idx == USC_IDX_TXD);
    wire       hit_rxd  = algn & (idx == USC_IDX_RXD);
    wire       hit_brg  = algn & (idx == USC_IDX_BRG);
    wire       hit      = hit_mode | hit_stat | hit_txd | hit_rxd | hit_brg;
    wire       wr_stat  = wr & hit_stat;

    wire       uart_on  = mode_r[USC_M_ON];
    wire       infrared_codec_enable     = mode_r[USC_M_INFRARED_CODEC_ENABLE];
    wire       brgh     = mode_r[USC_M_BRGH];
    wire [1:0] pds      = mode_r[USC_M_PDS +: 2];
    wire       nine     = pds == USC_PDS_NINE;
    wire       par_on   = (pds == USC_PDS_EVEN) | (pds == USC_PDS_ODD);
    wire       par_odd  = pds == USC_PDS_ODD;
    wire [3:0] bt_last  = brgh ? USC_LAST_HI : USC_LAST_STD;
    wire [3:0] bt_half  = brgh ? USC_HALF_HI : USC_HALF_STD;

    // ==========================================================
    // Baud tick
    logic [15:0] brg_cnt_r;
    wire         tick = uart_on & (brg_cnt_r == brg_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brg_cnt_r <= 16'h0;
        end else if (ce) begin
            brg_cnt_r <= (!uart_on || tick) ? 16'h0 : brg_cnt_r + 16'h1;
        end
    end

    // ==========================================================
    // Transmit buffer and shifter
    logic [8:0] tx_mem [USC_DEPTH];
    logic [1:0] tx_wp_r, tx_rp_r;
    logic [2:0] tx_cnt_r;
    usc_st_t    tx_st_r;
    logic [3:0] tx_ph_r, tx_bits_r;
    logic [8:0] tx_sh_r;
    logic       tx_par_r, tx_paren_r, tx_stop2_r, tx_isbrk_r;

    wire       tx_full  = tx_cnt_r == USC_CNT_FULL;
    wire       tx_push  = wr & hit_txd & txen_r & ~tx_full;
    wire       tx_load  = (tx_st_r == USC_IDLE) & (tx_cnt_r != 3'h0) & txen_r & uart_on;
    wire [8:0] tx_head  = tx_mem[tx_rp_r];
    wire       tx_end   = tick & (tx_ph_r == bt_last);
    wire       tx_fin   = tx_end & (tx_st_r == USC_STOP) & ~tx_stop2_r;
    wire       tx_all_empty     = (tx_st_r == USC_IDLE) & (tx_cnt_r == 3'h0);
    wire       tx_line  = (tx_st_r == USC_START) ? 1'b0 :
                          (tx_st_r == USC_DATA)  ? tx_sh_r[0] :
                          (tx_st_r == USC_PAR)   ? tx_par_r : 1'b1;
    // Zero bits become a short pulse against the idle level
    wire       ir_bit   = (!tx_line && tx_ph_r < USC_IR_PULSE) ? ~inv_r : inv_r;
    wire       pin_nxt  = infrared_codec_enable ? ir_bit : tx_line;
    wire       txi_nxt  = (tx_load & (tx_sel_r == USC_TXI_EACH)) |
                          (tx_load & (tx_sel_r == USC_TXI_EMPTY) & (tx_cnt_r == 3'h1) & ~tx_push) |
                          (tx_fin & (tx_sel_r == USC_TXI_DONE) & (tx_cnt_r == 3'h0));

    always_ff @(posedge pclk) begin
        if (ce && tx_push) begin
            tx_mem[tx_wp_r] <= pwdata[8:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_wp_r  <= 2'h0;
            tx_rp_r  <= 2'h0;
            tx_cnt_r <= 3'h0;
        end else if (ce) begin
            if (!txen_r) begin
                tx_wp_r  <= 2'h0;
                tx_rp_r  <= 2'h0;
                tx_cnt_r <= 3'h0;
            end else begin
                tx_wp_r  <= tx_wp_r + {1'b0, tx_push};
                tx_rp_r  <= tx_rp_r + {1'b0, tx_load};
                tx_cnt_r <= tx_cnt_r + {2'h0, tx_push} - {2'h0, tx_load};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_r    <= USC_IDLE;
            tx_ph_r    <= 4'h0;
            tx_bits_r  <= 4'h0;
            tx_sh_r    <= 9'h0;
            tx_par_r   <= 1'b0;
            tx_paren_r <= 1'b0;
            tx_stop2_r <= 1'b0;
            tx_isbrk_r <= 1'b0;
        end else if (ce) begin
            if (!txen_r || !uart_on) begin
                tx_st_r <= USC_IDLE;
            end else if (tx_load) begin
                tx_st_r    <= USC_START;
                tx_ph_r    <= 4'h0;
                // A break ignores the loaded character and sends zeros
                tx_sh_r    <= brk_r ? 9'h0 : tx_head;
                tx_bits_r  <= brk_r ? USC_BREAK_BITS : (nine ? USC_BITS9 : USC_BITS8);
                tx_paren_r <= ~brk_r & par_on;
                tx_par_r   <= ^tx_head[7:0] ^ par_odd;
                tx_stop2_r <= mode_r[USC_M_STSEL];
                tx_isbrk_r <= brk_r;
            end else if (tick && tx_st_r != USC_IDLE) begin
                tx_ph_r <= tx_end ? 4'h0 : tx_ph_r + 4'h1;
                if (tx_end) begin
                    unique case (tx_st_r)
                        USC_START: tx_st_r <= USC_DATA;
                        USC_DATA: begin
                            tx_sh_r   <= {1'b0, tx_sh_r[8:1]};
                            tx_bits_r <= tx_bits_r - 4'h1;
                            if (tx_bits_r == 4'h1) begin
                                tx_st_r <= tx_paren_r ? USC_PAR : USC_STOP;
                            end
                        end
                        USC_PAR:  tx_st_r <= USC_STOP;
                        USC_STOP: begin
                            if (tx_stop2_r) begin
                                tx_stop2_r <= 1'b0;
                            end else begin
                                tx_st_r <= USC_IDLE;
                            end
                        end
                        default:  tx_st_r <= USC_IDLE;
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // Receive shifter and buffer
    logic [10:0] rx_mem [USC_DEPTH];
    logic [1:0]  rx_wp_r, rx_rp_r;
    logic [2:0]  rx_cnt_r;
    usc_st_t     rx_st_r;
    logic [3:0]  rx_ph_r, rx_bits_r;
    logic [8:0]  rx_sh_r;
    logic        rx_pbad_r;

    wire        overrun_flag_clr  = wr_stat & ~pwdata[USC_S_OVERRUN_FLAG] & overrun_flag_r;
    wire        rx_end    = tick & (rx_ph_r == ((rx_st_r == USC_START) ? bt_half : bt_last));
    wire        rx_done   = rx_end & (rx_st_r == USC_STOP);
    wire [8:0]  rx_char   = nine ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
    wire        rx_keep   = ~(address_detect_enable_r & nine & ~rx_char[8]);
    wire        rx_try    = rx_done & rx_keep & ~overrun_flag_clr;
    wire        rx_full   = rx_cnt_r == USC_CNT_FULL;
    wire        rx_ovf    = rx_try & rx_full;
    wire        rx_push   = rx_try & ~rx_full;
    wire        rx_avail  = rx_cnt_r != 3'h0;
    wire        rx_pop    = rd & hit_rxd & rx_avail;
    wire [10:0] rx_head   = rx_avail ? rx_mem[rx_rp_r] : 11'h0;
    wire [2:0]  rx_after  = rx_cnt_r + 3'h1;
    wire        rxi_nxt   = rx_push & (~rx_sel_r[1] |
                            ((rx_sel_r == USC_RXI_3Q) & (rx_after == USC_CNT_3Q)) |
                            ((rx_sel_r == USC_RXI_FULL) & (rx_after == USC_CNT_FULL)));

    always_ff @(posedge pclk) begin
        if (ce && rx_push) begin
            rx_mem[rx_wp_r] <= {~serial_in, rx_pbad_r, rx_char};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_wp_r  <= 2'h0;
            rx_rp_r  <= 2'h0;
            rx_cnt_r <= 3'h0;
        end else if (ce) begin
            if (overrun_flag_clr) begin
                rx_wp_r  <= 2'h0;
                rx_rp_r  <= 2'h0;
                rx_cnt_r <= 3'h0;
            end else begin
                rx_wp_r  <= rx_wp_r + {1'b0, rx_push};
                rx_rp_r  <= rx_rp_r + {1'b0, rx_pop};
                rx_cnt_r <= rx_cnt_r + {2'h0, rx_push} - {2'h0, rx_pop};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_r   <= USC_IDLE;
            rx_ph_r   <= 4'h0;
            rx_bits_r <= 4'h0;
            rx_sh_r   <= 9'h0;
            rx_pbad_r <= 1'b0;
        end else if (ce) begin
            if (!uart_on || overrun_flag_clr) begin
                rx_st_r <= USC_IDLE;
            end else if (rx_st_r == USC_IDLE) begin
                if (!serial_in) begin
                    rx_st_r <= USC_START;
                    rx_ph_r <= 4'h0;
                end
            end else if (tick) begin
                rx_ph_r <= rx_end ? 4'h0 : rx_ph_r + 4'h1;
                if (rx_end) begin
                    unique case (rx_st_r)
                        USC_START: begin
                            // A start bit gone high by mid-bit was noise
                            rx_st_r   <= serial_in ? USC_IDLE : USC_DATA;
                            rx_bits_r <= nine ? USC_BITS9 : USC_BITS8;
                            rx_pbad_r <= 1'b0;
                        end
                        USC_DATA: begin
                            rx_sh_r   <= {serial_in, rx_sh_r[8:1]};
                            rx_bits_r <= rx_bits_r - 4'h1;
                            if (rx_bits_r == 4'h1) begin
                                rx_st_r <= par_on ? USC_PAR : USC_STOP;
                            end
                        end
                        USC_PAR: begin
                            rx_pbad_r <= ^rx_sh_r[8:1] ^ serial_in ^ par_odd;
                            rx_st_r   <= USC_STOP;
                        end
                        default: rx_st_r <= USC_IDLE;
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // Control registers and read data
    wire [15:0] stat_rd = {tx_sel_r[1], inv_r, tx_sel_r[0], 1'b0, brk_r, txen_r,
                           tx_full, tx_all_empty, rx_sel_r, address_detect_enable_r, rx_st_r == USC_IDLE,
                           rx_head[9], rx_head[10], overrun_flag_r, rx_avail};
    wire [15:0] rd_mux  = hit_mode ? mode_r :
                          hit_stat ? stat_rd :
                          hit_rxd  ? {7'h0, rx_head[8:0]} :
                          hit_brg  ? brg_r : 16'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else if (ce) begin
            pready_r  <= acc;
            pslverr_r <= acc & ~hit;
            if (acc && !pwrite) begin
                prdata_r <= {16'h0, rd_mux};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r   <= USC_MODE_RST;
            brg_r    <= USC_BRG_RST;
            tx_sel_r <= {USC_STAT_RST[USC_S_TXI1], USC_STAT_RST[USC_S_TXI0]};
            inv_r    <= USC_STAT_RST[USC_S_INV];
            brk_r    <= USC_STAT_RST[USC_S_BRK];
            txen_r   <= USC_STAT_RST[USC_S_TXEN];
            rx_sel_r <= USC_STAT_RST[USC_S_RXI +: 2];
            address_detect_enable_r  <= USC_STAT_RST[USC_S_ADDRESS_DETECT_ENABLE];
            overrun_flag_r   <= USC_STAT_RST[USC_S_OVERRUN_FLAG];
        end else if (ce) begin
            if (wr && hit_mode) begin
                mode_r <= pwdata[15:0] & USC_MODE_WMASK;
            end
            if (wr && hit_brg) begin
                brg_r <= pwdata[15:0];
            end
            if (wr_stat) begin
                tx_sel_r <= {pwdata[USC_S_TXI1], pwdata[USC_S_TXI0]};
                inv_r    <= pwdata[USC_S_INV];
                txen_r   <= pwdata[USC_S_TXEN];
                rx_sel_r <= pwdata[USC_S_RXI +: 2];
                address_detect_enable_r  <= pwdata[USC_S_ADDRESS_DETECT_ENABLE];
                brk_r    <= pwdata[USC_S_BRK];
            end else if (tx_fin && tx_isbrk_r) begin
                brk_r <= 1'b0;
            end
            // A new overflow in the clearing cycle is dropped, so the flag clears
            overrun_flag_r <= rx_ovf | (overrun_flag_r & ~overrun_flag_clr);
        end
    end

    // ==========================================================
    // Outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_irq_r <= 1'b0;
            rx_irq_r <= 1'b0;
            pin_r    <= 1'b1;
            oe_n_r   <= 1'b1;
        end else if (ce) begin
            tx_irq_r <= txi_nxt;
            rx_irq_r <= rxi_nxt;
            pin_r    <= pin_nxt;
            oe_n_r   <= ~(uart_on & txen_r);
        end
    end

    assign prdata              = prdata_r;
    assign pready              = pready_r;
    assign pslverr             = pslverr_r;
    assign tx_irq              = tx_irq_r;
    assign rx_irq              = rx_irq_r;
    assign serial_out_pin      = pin_r;
    assign serial_out_pin_oe_n = oe_n_r;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tx_empty_irq: assert property (ce && tx_load && tx_sel_r == USC_TXI_EMPTY && tx_cnt_r == 3'h1 && !tx_push |=> tx_irq_r)
        else $error("no irq when buffer emptied");
    a_tx_done_irq: assert property (ce && tx_fin && tx_sel_r == USC_TXI_DONE && tx_cnt_r == 3'h0 && !tx_push |=> tx_irq_r && tx_all_empty)
        else $error("no irq at end of transmission");
    a_tx_each_irq: assert property (ce && tx_sel_r == USC_TXI_EACH |=> tx_irq_r == $past(tx_load))
        else $error("irq does not follow load");
    a_break_len: assert property (ce && tx_load && brk_r |=> tx_bits_r == USC_BREAK_BITS && tx_sh_r == 9'h0)
        else $error("break not twelve zero bits");
    a_txen_flush: assert property (ce && !txen_r |=> tx_cnt_r == 3'h0 && tx_st_r == USC_IDLE && oe_n_r)
        else $error("transmit disable did not flush");
    a_tx_busy_flag: assert property (tx_st_r != USC_IDLE |-> !stat_rd[8] && (stat_rd[9] == (tx_cnt_r == 3'(USC_DEPTH))))
        else $error("transmit flags wrong while busy");
    a_rx_full_irq: assert property (ce && rx_push && rx_sel_r == USC_RXI_FULL |=> rx_irq_r == (rx_cnt_r == USC_CNT_FULL))
        else $error("full irq mismatch");
    a_rx_3q_irq: assert property (ce && rx_push && rx_sel_r == USC_RXI_3Q |=> rx_irq_r == (rx_cnt_r == USC_CNT_3Q))
        else $error("three-quarter irq mismatch");
    a_rx_any_irq: assert property (ce && rx_push && !rx_sel_r[1] |=> rx_irq_r)
        else $error("no irq on received character");
    a_addr_filter: assert property (rx_done && address_detect_enable_r && nine && !rx_char[8] |-> !rx_push)
        else $error("data character kept in address mode");
    a_overrun_flag_flush: assert property (ce && overrun_flag_clr |=> rx_cnt_r == 3'h0 && rx_st_r == USC_IDLE)
        else $error("overrun clear did not flush");
    a_overrun_flag_set: assert property (ce && rx_ovf && !rx_pop |=> overrun_flag_r && rx_cnt_r == USC_CNT_FULL)
        else $error("overflow did not set overrun");
    a_rx_advance: assert property (ce && rx_pop && !rx_push && !overrun_flag_clr |=> rx_cnt_r == $past(rx_cnt_r) - 3'h1)
        else $error("receive read did not advance");
endmodule // usc_uart_status_control

// >>> usc_uart_status_control_bench.sv
// Self-checking testbench for the serial port status and control block
`timescale 1ns/100ps
module usc_uart_status_control_bench
    import usc_pkg::*;
;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic        serial_in, serial_out_pin, serial_out_pin_oe_n, tx_irq, rx_irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  b;
    int          failures, n_checks, tx_cnt, rx_cnt, c0, lw;
    localparam logic [11:0] A_MODE = {USC_IDX_MODE, 2'b00};
    localparam logic [11:0] A_STAT = {USC_IDX_STAT, 2'b00};
    localparam logic [11:0] A_TXD  = {USC_IDX_TXD, 2'b00};
    localparam logic [11:0] A_RXD  = {USC_IDX_RXD, 2'b00};
    usc_uart_status_control dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_in(serial_in), .serial_out_pin(serial_out_pin), .serial_out_pin_oe_n(serial_out_pin_oe_n),
        .tx_irq(tx_irq), .rx_irq(rx_irq));
    usc_line_partner partner_u (.pclk(pclk), .line_from_dut(serial_out_pin), .line_to_dut(serial_in));
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        if (tx_irq === 1'b1) tx_cnt <= tx_cnt + 1;
        if (rx_irq === 1'b1) rx_cnt <= rx_cnt + 1;
    end
    // =========
    // Bus and compare tasks
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic results;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // =========
    // Scenarios
    task automatic t_reset;
        rd(A_STAT, 32'h0000_0110);
        rd(A_MODE, 32'h0);
        apb(1'b0, 12'h8a4, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk({31'h0, serial_out_pin_oe_n}, 32'h1);
        wr(A_MODE, 32'h0000_8008);
        $display("test reset done");
    endtask
    task automatic t_tx_modes;
        logic [15:0] sel [3] = '{16'h0400, 16'h2400, 16'h8400};
        int          early [3] = '{1, 0, 1};
        for (int m = 0; m < 3; m++) begin
            wr(A_STAT, {16'h0, sel[m]});
            repeat (2) @(posedge pclk);
            chk({31'h0, serial_out_pin_oe_n}, 32'h0);
            c0 = tx_cnt;
            fork
                begin
                    wr(A_TXD, 32'ha5 ^ m);
                    repeat (3) @(posedge pclk);
                    chk(tx_cnt - c0, early[m]);
                end
                partner_u.recv(b);
            join
            chk({24'h0, b}, 32'ha5 ^ m);
            repeat (12) @(posedge pclk);
            chk(tx_cnt - c0, 32'h1);
            rd(A_STAT, {16'h0, sel[m] | 16'h0110});
        end
        $display("test tx modes done");
    endtask
    task automatic t_tx_full;
        wr(A_STAT, 32'h0400);
        for (int k = 0; k < 5; k++) begin
            wr(A_TXD, k);
            if (k == 3) rd(A_STAT, 32'h0410);
        end
        rd(A_STAT, 32'h0610);
        wr(A_STAT, 32'h0);
        rd(A_STAT, 32'h0110);
        chk({31'h0, serial_out_pin_oe_n}, 32'h1);
        $display("test tx full done");
    endtask
    task automatic t_rx_modes;
        logic [15:0] sel [3] = '{16'h0000, 16'h0080, 16'h00c0};
        int          exp [3] = '{4, 1, 1};
        for (int m = 0; m < 3; m++) begin
            wr(A_STAT, {16'h0, sel[m]});
            c0 = rx_cnt;
            for (int k = 0; k < 4; k++) partner_u.send(8'h30 + k);
            repeat (12) @(posedge pclk);
            chk(rx_cnt - c0, exp[m]);
            rd(A_STAT, {16'h0, sel[m] | 16'h0111});
            for (int k = 0; k < 4; k++) rd(A_RXD, 32'h30 + k);
            rd(A_STAT, {16'h0, sel[m] | 16'h0110});
        end
        $display("test rx modes done");
    endtask
    task automatic t_overrun;
        wr(A_STAT, 32'h00c0);
        for (int k = 0; k < 4; k++) partner_u.send(8'h40 + k);
        fork
            partner_u.send(8'h44);
            begin
                repeat (12) @(posedge pclk);
                apb(1'b0, A_STAT, 32'h0);
                chk({31'h0, q[4]}, 32'h0);
            end
        join
        repeat (12) @(posedge pclk);
        rd(A_STAT, 32'h01d3);
        rd(A_RXD, 32'h40);
        wr(A_STAT, 32'h00c0);
        rd(A_STAT, 32'h01d0);
        $display("test overrun done");
    endtask
    task automatic t_break;
        wr(A_STAT, 32'h0c00);
        fork
            wr(A_TXD, 32'hff);
            begin
                lw = 0;
                while (serial_out_pin !== 1'b0 && lw < 100) begin
                    @(posedge pclk);
                    lw++;
                end
                lw = 0;
                while (serial_out_pin === 1'b0 && lw < 200) begin
                    @(posedge pclk);
                    lw++;
                end
            end
        join
        chk(lw, 32'd52);
        repeat (12) @(posedge pclk);
        rd(A_STAT, 32'h0510);
        $display("test break done");
    endtask
    task automatic t_rx_frames;
        wr(A_MODE, 32'h0000_800e);
        wr(A_STAT, 32'h0020);
        partner_u.send(9'h055, 1'b1);
        partner_u.send(9'h1a5, 1'b1);
        repeat (12) @(posedge pclk);
        rd(A_STAT, 32'h0131);
        rd(A_RXD, 32'h1a5);
        wr(A_MODE, 32'h0000_8008);
        wr(A_STAT, 32'h0);
        partner_u.send(9'h061, 1'b0, 1'b0);
        partner_u.send(9'h062);
        repeat (12) @(posedge pclk);
        rd(A_STAT, 32'h0115);
        rd(A_RXD, 32'h61);
        rd(A_STAT, 32'h0111);
        rd(A_RXD, 32'h62);
        $display("test rx frames done");
    endtask
    task automatic t_ir;
        wr(A_MODE, 32'h0000_9000);
        wr(A_STAT, 32'h4400);
        repeat (2) @(posedge pclk);
        chk({31'h0, serial_out_pin}, 32'h1);
        wr(A_STAT, 32'h0400);
        repeat (2) @(posedge pclk);
        chk({31'h0, serial_out_pin}, 32'h0);
        wr(A_MODE, 32'h0000_8000);
        repeat (2) @(posedge pclk);
        chk({31'h0, serial_out_pin}, 32'h1);
        $display("test infrared done");
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        failures = 0;
        n_checks = 0;
        tx_cnt = 0;
        rx_cnt = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_tx_modes;
        t_tx_full;
        t_rx_modes;
        t_overrun;
        t_break;
        t_rx_frames;
        t_ir;
        results;
    end
    // Far above the few thousand cycles the scenarios need
    initial begin
        #2000000;
        failures++;
        results;
    end
endmodule // usc_uart_status_control_bench
